// ==== hw/sisp_prog_port.v ====
// serial in-system programming port: link, command decoder, memories, fuses
// Notes on behaviour
// - link works only while reset pin low
// - enable command required before program or erase
// - eeprom write self-erases, no chip erase needed
// - chip erase sets flash and eeprom all ones
// - flash words 0..1FF, eeprom bytes 0..3F
// - sample on sck rise, change output on fall
// - in sync, 53 echoes during third enable byte
// - one byte per write command, then poll/wait
// - busy address reads all ones until done
// - read returns stored byte in fourth byte
// - enable is AC 53 then two free bytes
// - erase is AC, second byte top bits 100
// - program read 0010H000, address a:b, data byte4
// - program write 0100H000, address a:b, data byte4
// - eeprom read A0, write C0, six-bit address
// - lock write AC 111xx, read 58, zero programmed
// - fuse write AC 101, read 50, zero programmed
// - only chip erase clears programmed lock bits
`timescale 1ns/1ps
`default_nettype none
`include "sisp_regs.vh"

module sisp_prog_port #(
    parameter FLASH_WORDS = 512,
    parameter EE_BYTES = 64,
    parameter ERASE_CYC = (`SISP_T_ERASE_US * 1000 + `SISP_MCLK_PS / 1000 - 1) / (`SISP_MCLK_PS / 1000),
    parameter FLASH_CYC = (`SISP_T_FLASH_US * 1000 + `SISP_MCLK_PS / 1000 - 1) / (`SISP_MCLK_PS / 1000),
    parameter EE_CYC = (`SISP_T_EEPROM_US * 1000 + `SISP_MCLK_PS / 1000 - 1) / (`SISP_MCLK_PS / 1000)
) (
    input wire mclk,
    input wire rst,
    input wire reset_pin_n,
    input wire sck,
    input wire mosi,
    output wire miso_out,
    output wire miso_oe,
    output wire prog_enabled,
    output wire write_busy,
    output wire link_overrun,
    output wire lock_bit_one,
    output wire lock_bit_two,
    output wire clock_select_fuse_low,
    output wire clock_select_fuse_high,
    output wire reset_pin_disable_fuse,
    output wire serial_programming_allow_fuse,
    output wire brownout_detect_fuse,
    output wire brownout_threshold_fuse
);
    // ****************************************
    // constants and helpers
    // ****************************************
    localparam [1:0] BUSY_NONE = 2'h0;
    localparam [1:0] BUSY_FLASH = 2'h1;
    localparam [1:0] BUSY_EE = 2'h2;
    localparam [1:0] BUSY_ERASE = 2'h3;
    localparam [23:0] ERASE_LD = ERASE_CYC[23:0];
    localparam [23:0] FLASH_LD = FLASH_CYC[23:0];
    localparam [23:0] EE_LD = EE_CYC[23:0];

    function is_sub;
        input [7:0] b1;
        input [7:0] b2;
        input [2:0] sub;
        begin
            is_sub = (b1 == `SISP_OP_ENABLE) && (b2[7:5] == sub);
        end
    endfunction

    function is_prog;
        input [7:0] b1;
        input [7:0] op;
        begin
            is_prog = ((b1 & `SISP_OP_PROG_MASK) == op);
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [1:0] rstn_sync_r;
    reg [1:0] sck_sync_r;
    reg [1:0] mosi_sync_r;
    reg sck_prev_r;
    wire session;
    wire sck_rise;
    wire sck_fall;

    always @(posedge mclk) begin
        if (rst) begin
            rstn_sync_r <= 2'h3;
            sck_sync_r <= 2'h0;
            mosi_sync_r <= 2'h0;
            sck_prev_r <= 1'b0;
        end else begin
            rstn_sync_r <= {rstn_sync_r[0], reset_pin_n};
            sck_sync_r <= {sck_sync_r[0], sck};
            mosi_sync_r <= {mosi_sync_r[0], mosi};
            sck_prev_r <= sck_sync_r[1];
        end
    end

    assign session = !rstn_sync_r[1];
    assign sck_rise = session && sck_sync_r[1] && !sck_prev_r;
    assign sck_fall = session && !sck_sync_r[1] && sck_prev_r;

    // ****************************************
    // bit shifter, msb first
    // ****************************************
    reg [2:0] bit_cnt_r;
    reg [7:0] rx_sh_r;
    reg [7:0] tx_sh_r;
    reg [7:0] tx_next_r;
    reg rx_valid_r;
    reg [7:0] rx_byte_r;
    reg miso_r;
    reg overrun_r;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [7:0] buf_out_data;
    wire proc_ready;

    always @(posedge mclk) begin
        if (rst || !session) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_byte_r <= 8'h00;
            miso_r <= 1'b0;
            overrun_r <= rst ? 1'b0 : overrun_r;
        end else begin
            rx_valid_r <= 1'b0;
            if (sck_rise) begin
                rx_sh_r <= {rx_sh_r[6:0], mosi_sync_r[1]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7) begin
                    rx_byte_r <= {rx_sh_r[6:0], mosi_sync_r[1]};
                    rx_valid_r <= 1'b1;
                end
            end
            // the pin cannot be stalled, so a full buffer can only be flagged
            if (rx_valid_r && !buf_in_ready) begin
                overrun_r <= 1'b1;
            end
            if (sck_fall) begin
                if (bit_cnt_r == 3'h0) begin
                    miso_r <= tx_next_r[7];
                    tx_sh_r <= {tx_next_r[6:0], 1'b0};
                end else begin
                    miso_r <= tx_sh_r[7];
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    sisp_byte_buf #(
        .WIDTH(8)
    ) u_buf (
        .mclk(mclk),
        .rst(rst),
        .flush(!session),
        .in_valid(rx_valid_r),
        .in_ready(buf_in_ready),
        .in_data(rx_byte_r),
        .out_valid(buf_out_valid),
        .out_ready(proc_ready),
        .out_data(buf_out_data)
    );

    // ****************************************
    // storage and nonvolatile state
    // ****************************************
    reg [7:0] flash_lo_r [0:FLASH_WORDS-1];
    reg [7:0] flash_hi_r [0:FLASH_WORDS-1];
    reg [7:0] ee_r [0:EE_BYTES-1];
    reg [1:0] lock_r;
    reg [5:0] fuse_r;

    // ****************************************
    // command decoder
    // ****************************************
    reg [1:0] idx_r;
    reg [7:0] b1_r;
    reg [7:0] b2_r;
    reg [7:0] b3_r;
    reg enabled_r;
    reg [1:0] busy_kind_r;
    reg [23:0] busy_cnt_r;
    reg [8:0] wr_addr_r;
    reg wr_high_r;
    reg [7:0] wr_data_r;
    reg miso_oe_r;
    wire take;
    wire commit;
    wire [8:0] pa;
    wire [5:0] ea;
    wire flash_busy_hit;
    wire ee_busy_hit;
    integer i;

    // a commit cycle stalls the decoder; the buffer absorbs the byte
    assign commit = (busy_cnt_r == 24'h00_0001) && (busy_kind_r != BUSY_NONE);
    assign proc_ready = !commit;
    assign take = buf_out_valid && proc_ready;
    assign pa = {b2_r[0], buf_out_data};
    assign ea = buf_out_data[5:0];
    assign flash_busy_hit = (busy_kind_r == BUSY_FLASH) && (wr_addr_r == pa);
    assign ee_busy_hit = (busy_kind_r == BUSY_EE) && (wr_addr_r[5:0] == ea);

    always @(posedge mclk) begin
        if (rst) begin
            idx_r <= 2'h0;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            b3_r <= 8'h00;
            enabled_r <= 1'b0;
            tx_next_r <= `SISP_TX_RST;
            busy_kind_r <= BUSY_NONE;
            busy_cnt_r <= 24'h00_0000;
            wr_addr_r <= 9'h000;
            wr_high_r <= 1'b0;
            wr_data_r <= 8'h00;
            miso_oe_r <= 1'b0;
            lock_r <= `SISP_LOCK_RST;
            fuse_r <= `SISP_FUSE_RST;
            // modelled part starts erased
            for (i = 0; i < FLASH_WORDS; i = i + 1) begin
                flash_lo_r[i] <= `SISP_ERASED_BYTE;
                flash_hi_r[i] <= `SISP_ERASED_BYTE;
            end
            for (i = 0; i < EE_BYTES; i = i + 1) begin
                ee_r[i] <= `SISP_ERASED_BYTE;
            end
        end else begin
            miso_oe_r <= session;
            // write timer keeps running across a session end
            if (busy_cnt_r != 24'h00_0000) begin
                busy_cnt_r <= busy_cnt_r - 24'h00_0001;
            end
            if (commit) begin
                busy_kind_r <= BUSY_NONE;
                if (busy_kind_r == BUSY_FLASH) begin
                    if (wr_high_r) begin
                        flash_hi_r[wr_addr_r] <= wr_data_r;
                    end else begin
                        flash_lo_r[wr_addr_r] <= wr_data_r;
                    end
                end else if (busy_kind_r == BUSY_EE) begin
                    ee_r[wr_addr_r[5:0]] <= wr_data_r;
                end
            end
            if (!session) begin
                idx_r <= 2'h0;
                enabled_r <= 1'b0;
                tx_next_r <= `SISP_TX_RST;
            end else if (take) begin
                idx_r <= idx_r + 2'h1;
                // only an aligned key is echoed, so a slipped frame never shows it
                tx_next_r <= `SISP_TX_RST;
                if (idx_r == 2'h0) begin
                    b1_r <= buf_out_data;
                end else if (idx_r == 2'h1) begin
                    b2_r <= buf_out_data;
                    if (b1_r == `SISP_OP_ENABLE && buf_out_data == `SISP_ENABLE_KEY) begin
                        tx_next_r <= `SISP_ENABLE_KEY;
                    end
                end else if (idx_r == 2'h2) begin
                    b3_r <= buf_out_data;
                    if (enabled_r) begin
                        if (is_prog(b1_r, `SISP_OP_RD_PROG)) begin
                            if (flash_busy_hit && (wr_high_r == b1_r[`SISP_HIGH_SEL_BIT])) begin
                                tx_next_r <= `SISP_ERASED_BYTE;
                            end else if (b1_r[`SISP_HIGH_SEL_BIT]) begin
                                tx_next_r <= flash_hi_r[pa];
                            end else begin
                                tx_next_r <= flash_lo_r[pa];
                            end
                        end else if (b1_r == `SISP_OP_RD_EE) begin
                            tx_next_r <= ee_busy_hit ? `SISP_ERASED_BYTE : ee_r[ea];
                        end else if (b1_r == `SISP_OP_RD_LOCK) begin
                            tx_next_r <= {5'h1F, lock_r, 1'b1};
                        end else if (b1_r == `SISP_OP_RD_FUSE) begin
                            tx_next_r <= {fuse_r[5:2], 2'h3, fuse_r[1:0]};
                        end
                    end
                end else begin
                    if (!enabled_r) begin
                        if (b1_r == `SISP_OP_ENABLE && b2_r == `SISP_ENABLE_KEY) begin
                            enabled_r <= 1'b1;
                        end
                    end else if (is_sub(b1_r, b2_r, `SISP_SUB_ERASE)) begin
                        if (busy_kind_r == BUSY_NONE || commit) begin
                            for (i = 0; i < FLASH_WORDS; i = i + 1) begin
                                flash_lo_r[i] <= `SISP_ERASED_BYTE;
                                flash_hi_r[i] <= `SISP_ERASED_BYTE;
                            end
                            for (i = 0; i < EE_BYTES; i = i + 1) begin
                                ee_r[i] <= `SISP_ERASED_BYTE;
                            end
                            lock_r <= `SISP_LOCK_RST;
                            busy_kind_r <= BUSY_ERASE;
                            busy_cnt_r <= ERASE_LD;
                        end
                    end else if (is_sub(b1_r, b2_r, `SISP_SUB_LOCK)) begin
                        // a one cannot unprogram a lock bit
                        lock_r <= lock_r & b2_r[`SISP_LOCK_LO_BIT+1:`SISP_LOCK_LO_BIT];
                    end else if (is_sub(b1_r, b2_r, `SISP_SUB_FUSE)) begin
                        fuse_r <= {buf_out_data[7:4], buf_out_data[1:0]};
                    end else if (busy_kind_r != BUSY_NONE) begin
                        // flash and eeprom writes during a busy period are dropped
                        wr_data_r <= wr_data_r;
                    end else if (is_prog(b1_r, `SISP_OP_WR_PROG)) begin
                        wr_addr_r <= {b2_r[0], b3_r};
                        wr_high_r <= b1_r[`SISP_HIGH_SEL_BIT];
                        wr_data_r <= buf_out_data;
                        busy_kind_r <= BUSY_FLASH;
                        busy_cnt_r <= FLASH_LD;
                    end else if (b1_r == `SISP_OP_WR_EE) begin
                        wr_addr_r <= {3'h0, b3_r[5:0]};
                        wr_data_r <= buf_out_data;
                        busy_kind_r <= BUSY_EE;
                        busy_cnt_r <= EE_LD;
                    end
                end
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign miso_out = miso_r;
    assign miso_oe = miso_oe_r;
    assign prog_enabled = enabled_r;
    assign write_busy = (busy_kind_r != BUSY_NONE);
    assign link_overrun = overrun_r;
    assign lock_bit_one = lock_r[0];
    assign lock_bit_two = lock_r[1];
    assign clock_select_fuse_low = fuse_r[0];
    assign clock_select_fuse_high = fuse_r[1];
    assign reset_pin_disable_fuse = fuse_r[2];
    assign serial_programming_allow_fuse = fuse_r[3];
    assign brownout_detect_fuse = fuse_r[4];
    assign brownout_threshold_fuse = fuse_r[5];
endmodule // sisp_prog_port

`default_nettype wire

// ==== hw/sisp_regs.vh ====
// constants of the serial programming port: opcodes, reset values, timing
`ifndef SISP_REGS_VH
`define SISP_REGS_VH

// ****************************************
// clock and wait times
// ****************************************
`define SISP_MCLK_PS 5000
`define SISP_T_ERASE_US 8200
`define SISP_T_FLASH_US 4100
`define SISP_T_EEPROM_US 8200

// ****************************************
// command encodings
// ****************************************
`define SISP_OP_ENABLE 8'hAC
`define SISP_ENABLE_KEY 8'h53
`define SISP_OP_RD_PROG 8'h20
`define SISP_OP_WR_PROG 8'h40
`define SISP_OP_PROG_MASK 8'hF7
`define SISP_OP_RD_EE 8'hA0
`define SISP_OP_WR_EE 8'hC0
`define SISP_OP_RD_LOCK 8'h58
`define SISP_OP_RD_FUSE 8'h50
`define SISP_SUB_ERASE 3'h4
`define SISP_SUB_FUSE 3'h5
`define SISP_SUB_LOCK 3'h7
`define SISP_HIGH_SEL_BIT 3
`define SISP_LOCK_LO_BIT 1

// ****************************************
// reset and erased values
// ****************************************
`define SISP_ERASED_BYTE 8'hFF
`define SISP_LOCK_RST 2'h3
`define SISP_FUSE_RST 6'h37
`define SISP_TX_RST 8'h00

`endif

// ==== hw/sisp_byte_buf.v ====
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sisp_byte_buf #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot_r [0:1];
    reg rd_ptr_r;
    reg wr_ptr_r;
    reg [1:0] count_r;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = slot_r[rd_ptr_r];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @(posedge mclk) begin
        if (rst || flush) begin
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            count_r <= 2'h0;
            slot_r[0] <= {WIDTH{1'b0}};
            slot_r[1] <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                slot_r[wr_ptr_r] <= in_data;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (do_rd) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 2'h1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule // sisp_byte_buf

`default_nettype wire

// ==== testbench/sisp_prog_port_checker.sv ====
// checker of the serial programming port
`timescale 1ns/1ps
`default_nettype none
module sisp_prog_port_checker #(
    parameter ERASE_CYC = 1640000,
    parameter FLASH_CYC = 820000,
    parameter EE_CYC = 1640000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic prog_enabled,
    input wire logic write_busy,
    input wire logic link_overrun,
    input wire logic lock_bit_one,
    input wire logic lock_bit_two,
    input wire logic clock_select_fuse_low,
    input wire logic clock_select_fuse_high,
    input wire logic reset_pin_disable_fuse,
    input wire logic serial_programming_allow_fuse,
    input wire logic brownout_detect_fuse,
    input wire logic brownout_threshold_fuse
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic [31:0] busy_cnt_r;
    wire [5:0] fuse_v = {brownout_threshold_fuse, brownout_detect_fuse, serial_programming_allow_fuse,
        reset_pin_disable_fuse, clock_select_fuse_high, clock_select_fuse_low};
    // length of the current busy run
    always @(posedge mclk) begin
        busy_cnt_r <= (rst || !write_busy) ? 32'h0000_0000 : busy_cnt_r + 32'h0000_0001;
    end
    // one cycle of slack either way for the launch edge
    function automatic bit near(input logic [31:0] n, input int c);
        return (n + 1 >= c) && (n <= c + 1);
    endfunction
    oe_session_a: assert property (!reset_pin_n [*5] |-> miso_oe)
        else $error("miso enable low in session");
    oe_idle_a: assert property (reset_pin_n [*5] |-> !miso_oe && !prog_enabled)
        else $error("link active with reset pin high");
    enable_hold_a: assert property ((prog_enabled && !reset_pin_n) [*4] |=> prog_enabled)
        else $error("enable lost in session");
    busy_gate_a: assert property ($rose(write_busy) |-> $past(prog_enabled))
        else $error("write started while not enabled");
    busy_len_a: assert property ($fell(write_busy) |->
        near(busy_cnt_r, FLASH_CYC) || near(busy_cnt_r, EE_CYC) || near(busy_cnt_r, ERASE_CYC))
        else $error("busy run of wrong length");
    lock_one_erase_a: assert property ($rose(lock_bit_one) |-> write_busy || $past(write_busy))
        else $error("lock bit one cleared outside erase");
    lock_two_erase_a: assert property ($rose(lock_bit_two) |-> write_busy || $past(write_busy))
        else $error("lock bit two cleared outside erase");
    fuse_gate_a: assert property (!$stable(fuse_v) |-> prog_enabled)
        else $error("fuses changed while not enabled");
    miso_edge_a: assert property (miso_oe && $past(miso_oe) && !$stable(miso_out) |-> !sck &&
        ($past(sck, 2) || $past(sck, 3) || $past(sck, 4) || $past(sck, 5) || $past(sck, 6)))
        else $error("miso changed away from a clock fall");
    en_c: cover property ($rose(prog_enabled));
    busy_c: cover property ($fell(write_busy));
    lock_c: cover property ($fell(lock_bit_one));
    fuse_c: cover property (!$stable(fuse_v));
endmodule // sisp_prog_port_checker
bind sisp_prog_port sisp_prog_port_checker #(.ERASE_CYC(ERASE_CYC), .FLASH_CYC(FLASH_CYC), .EE_CYC(EE_CYC)) chk_u (.*);
`default_nettype wire

// ==== testbench/sisp_isp_master.sv ====
// far-side programmer model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module sisp_isp_master #(
    parameter int HALF_NS = 32,
    parameter int ENTRY_NS = 200,
    parameter int ERASE_NS = 8200,
    parameter int FLASH_NS = 4100,
    parameter int EE_NS = 8200
) (
    output var logic reset_pin_n,
    output var logic sck,
    output var logic mosi,
    input wire logic miso
);
    // ****
    // link tasks
    // ****
    initial begin
        reset_pin_n = 1'b0;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // msb first, four bytes back to back
    task automatic xfer(input logic [31:0] c, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            mosi = c[i];
            #(HALF_NS); // both phases well over two device cycles
            r[i] = miso;
            sck = 1'b1;
            #(HALF_NS);
            sck = 1'b0;
        end
        mosi = ~mosi; // inverted after the last bit: no stale level
        #(HALF_NS);
    endtask
    task automatic pulse();
        sck = 1'b1;
        #(HALF_NS);
        sck = 1'b0;
        #(HALF_NS);
    endtask
    // entry wait shortened for simulation
    task automatic session(input logic on);
        reset_pin_n = !on;
        #(ENTRY_NS);
    endtask
    task automatic enable(output logic ok);
        logic [31:0] r;
        ok = 1'b0;
        for (int n = 0; n < 32 && !ok; n++) begin
            xfer(32'hAC53_0000, r); // all four bytes even without echo
            ok = r[15:8] === 8'h53;
            if (!ok) begin
                pulse();
            end
        end
    endtask
    // fixed delay, polling unusable for all-ones data
    task automatic wr_wait(input logic [31:0] c, input int ns);
        logic [31:0] r;
        xfer(c, r);
        #(ns);
    endtask
    // erase, wait, reset pulse, restart
    task automatic erase(input logic [31:0] c);
        wr_wait(c, ERASE_NS);
        session(1'b0);
        session(1'b1);
    endtask
endmodule // sisp_isp_master
`default_nettype wire

// ==== testbench/sisp_prog_port_tb.sv ====
// self-checking bench of the serial programming port
`timescale 1ns/1ps
`default_nettype none
module sisp_prog_port_tb;
    // ****
    // bench
    // ****
    localparam int ERASE_CYC = 1400;
    localparam int FLASH_CYC = 600;
    localparam int EE_CYC = 1200;
    logic mclk;
    logic rst;
    logic ok;
    logic [31:0] r;
    int fail_count = 0;
    int compares = 0;
    wire reset_pin_n, sck, mosi, miso_out, miso_oe, prog_enabled, write_busy, link_overrun;
    wire lock_bit_one, lock_bit_two, clock_select_fuse_low, clock_select_fuse_high;
    wire reset_pin_disable_fuse, serial_programming_allow_fuse, brownout_detect_fuse, brownout_threshold_fuse;
    wire [5:0] fuse_v = {brownout_threshold_fuse, brownout_detect_fuse, serial_programming_allow_fuse,
        reset_pin_disable_fuse, clock_select_fuse_high, clock_select_fuse_low};
    // no pull on the line, so undriven shows the inverse
    wire miso_line = miso_oe ? miso_out : ~miso_out;
    sisp_prog_port #(.ERASE_CYC(ERASE_CYC), .FLASH_CYC(FLASH_CYC), .EE_CYC(EE_CYC)) dut_u (.*);
    sisp_isp_master #(.ERASE_NS(ERASE_CYC * 5 + 200), .FLASH_NS(FLASH_CYC * 5 + 200),
        .EE_NS(EE_CYC * 5 + 200)) p_u (.reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso_line));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [31:0] c, input logic [7:0] e);
        logic [31:0] q;
        p_u.xfer(c, q);
        chk(q[7:0], e);
    endtask
    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_sim();
    end
    initial begin
        rst = 1'b1;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        #200;
        chk({miso_oe, prog_enabled, write_busy, lock_bit_two, lock_bit_one}, 5'b10011);
        chk(fuse_v, 6'h37);
        p_u.session(1'b0);
        p_u.xfer(32'hAC53_0000, r);
        chk({miso_oe, prog_enabled}, 2'b00);
        p_u.session(1'b1);
        p_u.xfer(32'h4000_05A5, r);
        #50;
        chk(write_busy, 1'b0);
        $display("test session done");
        // stray pulse first, so the retry loop must realign
        p_u.pulse();
        p_u.enable(ok);
        chk({ok, prog_enabled}, 2'b11);
        rd(32'h2000_0500, 8'hFF);
        $display("test enable done");
        p_u.xfer(32'h4001_FF3C, r);
        #50;
        chk(write_busy, 1'b1);
        rd(32'h2001_FF00, 8'hFF);
        #(p_u.FLASH_NS);
        rd(32'h2001_FF00, 8'h3C);
        p_u.wr_wait(32'h4801_FFC3, p_u.FLASH_NS);
        rd(32'h2801_FF00, 8'hC3);
        rd(32'h2000_FF00, 8'hFF);
        $display("test flash done");
        p_u.wr_wait(32'hC000_3F5A, p_u.EE_NS);
        rd(32'hA000_3F00, 8'h5A);
        p_u.wr_wait(32'hC000_3F12, p_u.EE_NS);
        rd(32'hA000_FF00, 8'h12);
        rd(32'h2000_3F00, 8'hFF);
        $display("test eeprom done");
        p_u.xfer(32'hACA0_005A, r);
        rd(32'h5000_0000, 8'h5E);
        chk(fuse_v, 6'h16);
        $display("test fuses done");
        p_u.xfer(32'hACFD_0000, r);
        rd(32'h5800_0000, 8'hFD);
        p_u.xfer(32'hACFF_0000, r);
        rd(32'h5800_0000, 8'hFD);
        p_u.xfer(32'hACFB_0000, r);
        chk({lock_bit_two, lock_bit_one}, 2'b00);
        $display("test locks done");
        p_u.erase(32'hAC9F_0000);
        p_u.enable(ok);
        rd(32'h2001_FF00, 8'hFF);
        rd(32'h2801_FF00, 8'hFF);
        rd(32'hA000_3F00, 8'hFF);
        rd(32'h5800_0000, 8'hFF);
        chk({lock_bit_two, lock_bit_one, link_overrun}, 3'b110);
        $display("test erase done");
        end_sim();
    end
endmodule // sisp_prog_port_tb
`default_nettype wire
